// [inc/pua_regs.svh]
// Constants for the power-up address and debug-enable block
`ifndef PUA_REGS_SVH
`define PUA_REGS_SVH

`define PUA_CLK_MHZ 40
`define PUA_INIT_TIME_US 20000
`define PUA_INIT_CYCLES (`PUA_INIT_TIME_US * `PUA_CLK_MHZ)
`define PUA_RESET_EXIT_US 1000
`define PUA_SETTLE_CYCLES 8'h40

// Converter codes of the nine bin edges, each 1.25 times the one before
`define PUA_THR0 12'h258
`define PUA_THR1 12'h2EE
`define PUA_THR2 12'h3AA
`define PUA_THR3 12'h494
`define PUA_THR4 12'h5B9
`define PUA_THR5 12'h727
`define PUA_THR6 12'h8F1
`define PUA_THR7 12'hB2D
`define PUA_THR8 12'hDF8
`define PUA_FIRST_BIN 4'h3

`define PUA_ADDR_MULT 8'h0C
`define PUA_ADDR_MAX 8'h7F
`define PUA_ADDR_FALLBACK 7'h7E
`define PUA_SHARED_PINS 4
`define PUA_CLK_DROP_SLOT 4'h9

`endif

// [inc/pua_pkg.sv]
// Types shared by the power-up address and debug-enable block
package pua_pkg;
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_BIAS_UP,
    ST_CONV_UP,
    ST_BIAS_LO,
    ST_CONV_LO,
    ST_DECIDE,
    ST_WAIT_INIT,
    ST_RUN
  } pua_state_type;

  typedef struct packed {
    logic [2:0] rst_sync;
    logic pin_level;
    pua_state_type st;
    logic [19:0] init_cnt;
    logic [7:0] settle_cnt;
    logic adc_start;
    logic [3:0] bin_upper;
    logic bad_upper;
    logic [3:0] bin_lower;
    logic bad_lower;
    logic [6:0] address;
    logic fallback;
    logic jtag_en;
    logic [3:0] clk_div;
  } pua_regs_type;
endpackage

// [inc/pua_bin_if.sv]
// Carrier between the sequencer and the bin classifier
interface pua_bin_if;
  logic [11:0] code;
  logic [3:0] bin;
  logic short_hit;
  logic open_hit;
  modport classifier (input code, output bin, output short_hit, output open_hit);
  modport user (output code, input bin, input short_hit, input open_hit);
endinterface

// [rtl/pua_bin.sv]
// Classifies a converted address pin voltage into its address bin
`include "pua_regs.svh"
module pua_bin (
  pua_bin_if.classifier bif
);
  localparam int NTHR = 9;
  localparam logic [11:0] THR [0:NTHR-1] = '{`PUA_THR0, `PUA_THR1, `PUA_THR2, `PUA_THR3,
    `PUA_THR4, `PUA_THR5, `PUA_THR6, `PUA_THR7, `PUA_THR8};

  logic [NTHR-1:0] above;

  genvar i;
  generate
    for (i = 0; i < NTHR; i++)
    begin : g_edge
      assign above[i] = (bif.code >= THR[i]);
    end
  endgenerate

  // Edges are monotonic, so the count of edges passed is the bin offset
  always_comb
  begin
    logic [3:0] cnt;
    cnt = 4'h0;
    for (int k = 0; k < NTHR; k++)
    begin
      cnt = cnt + {3'h0, above[k]};
    end
    bif.bin = `PUA_FIRST_BIN + cnt;
    bif.short_hit = ~above[0];
    bif.open_hit = above[NTHR-1];
  end
endmodule // pua_bin

// [rtl/pua_powerup.sv]
// Power-up initialization, strap address decode and debug port enable
`include "pua_regs.svh"
module pua_powerup #(
  parameter logic [19:0] INIT_CYCLES = 20'(`PUA_INIT_CYCLES)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ext_reset_n,
  input wire logic flash_blank,
  output logic upper_bias_en,
  output logic lower_bias_en,
  output logic adc_start,
  output logic adc_sel_upper,
  input wire logic adc_done,
  input wire logic [11:0] adc_code,
  output logic [6:0] bus_address,
  output logic address_fallback,
  output logic address_valid,
  output logic jtag_enable,
  output logic boundary_scan_en,
  output logic [`PUA_SHARED_PINS-1:0] shared_pin_gpio_release,
  output logic sys_clk_en,
  output logic fast_pulse_width_output_hold_low,
  output logic pins_float,
  output logic init_done
);
  pua_pkg::pua_regs_type s_reg;
  pua_pkg::pua_regs_type s_next;
  logic in_run;
  logic port_off;

  pua_bin_if bif ();

  pua_bin u_bin (
    .bif(bif)
  );

  assign bif.code = adc_code;

  function automatic logic [7:0] pua_addr(input logic [3:0] hi, input logic [3:0] lo);
    pua_addr = 8'({4'h0, hi} * `PUA_ADDR_MULT) + {4'h0, lo};
  endfunction

  // Init time runs from the first bias step and stops in run, so a long run cannot wrap it
  function automatic logic pua_counting(input pua_pkg::pua_state_type st);
    pua_counting = (st != pua_pkg::ST_HOLD) && (st != pua_pkg::ST_RUN);
  endfunction

  // Bias stays on through the conversion so the pin holds its level while sampled
  function automatic logic pua_bias_on(input pua_pkg::pua_state_type st, input logic upper);
    if (upper)
    begin
      pua_bias_on = (st == pua_pkg::ST_BIAS_UP) || (st == pua_pkg::ST_CONV_UP);
    end
    else
    begin
      pua_bias_on = (st == pua_pkg::ST_BIAS_LO) || (st == pua_pkg::ST_CONV_LO);
    end
  endfunction

  always_comb
  begin
    logic [7:0] raw;
    logic bad;
    raw = pua_addr(s_reg.bin_upper, s_reg.bin_lower);
    bad = s_reg.bad_upper | s_reg.bad_lower | (raw > `PUA_ADDR_MAX);
    s_next = s_reg;
    s_next.adc_start = 1'b0;
    s_next.rst_sync = {s_reg.rst_sync[1:0], ext_reset_n};
    // A change counts only once the last two stages agree
    if (s_reg.rst_sync[1] == s_reg.rst_sync[2])
    begin
      s_next.pin_level = s_reg.rst_sync[2];
    end
    // Slot drop gives 9 enables in 10 cycles while debugging
    if (s_reg.clk_div == `PUA_CLK_DROP_SLOT)
    begin
      s_next.clk_div = 4'h0;
    end
    else
    begin
      s_next.clk_div = s_reg.clk_div + 4'h1;
    end
    if (pua_counting(s_reg.st) && s_reg.init_cnt != INIT_CYCLES)
    begin
      s_next.init_cnt = s_reg.init_cnt + 20'h1;
    end
    case (s_reg.st)
      pua_pkg::ST_HOLD:
      begin
        s_next.init_cnt = 20'h0;
        s_next.settle_cnt = 8'h0;
        if (s_reg.pin_level)
        begin
          s_next.st = pua_pkg::ST_BIAS_UP;
        end
      end
      pua_pkg::ST_BIAS_UP:
      begin
        s_next.settle_cnt = s_reg.settle_cnt + 8'h1;
        if (s_reg.settle_cnt == `PUA_SETTLE_CYCLES)
        begin
          s_next.settle_cnt = 8'h0;
          s_next.adc_start = 1'b1;
          s_next.st = pua_pkg::ST_CONV_UP;
        end
      end
      pua_pkg::ST_CONV_UP:
      begin
        if (adc_done)
        begin
          s_next.bin_upper = bif.bin;
          s_next.bad_upper = bif.short_hit | bif.open_hit;
          s_next.st = pua_pkg::ST_BIAS_LO;
        end
      end
      pua_pkg::ST_BIAS_LO:
      begin
        s_next.settle_cnt = s_reg.settle_cnt + 8'h1;
        if (s_reg.settle_cnt == `PUA_SETTLE_CYCLES)
        begin
          s_next.settle_cnt = 8'h0;
          s_next.adc_start = 1'b1;
          s_next.st = pua_pkg::ST_CONV_LO;
        end
      end
      pua_pkg::ST_CONV_LO:
      begin
        if (adc_done)
        begin
          s_next.bin_lower = bif.bin;
          s_next.bad_lower = bif.short_hit | bif.open_hit;
          s_next.st = pua_pkg::ST_DECIDE;
        end
      end
      pua_pkg::ST_DECIDE:
      begin
        // Only decision point; values then stay until the next reset
        s_next.fallback = bad;
        s_next.address = bad ? `PUA_ADDR_FALLBACK : raw[6:0];
        s_next.jtag_en = bad | flash_blank;
        s_next.st = pua_pkg::ST_WAIT_INIT;
      end
      pua_pkg::ST_WAIT_INIT:
      begin
        if (s_reg.init_cnt == INIT_CYCLES)
        begin
          s_next.st = pua_pkg::ST_RUN;
        end
      end
      pua_pkg::ST_RUN:
      begin
        s_next.init_cnt = s_reg.init_cnt;
      end
      default:
      begin
        s_next.st = pua_pkg::ST_HOLD;
      end
    endcase
    // Pin reset beats every state and clears the latched decision
    if (!s_reg.pin_level)
    begin
      s_next.st = pua_pkg::ST_HOLD;
      s_next.jtag_en = 1'b0;
      s_next.fallback = 1'b0;
      s_next.address = 7'h00;
      s_next.adc_start = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg.rst_sync <= 3'h0;
      s_reg.pin_level <= 1'b0;
      s_reg.st <= pua_pkg::ST_HOLD;
      s_reg.init_cnt <= 20'h0;
      s_reg.settle_cnt <= 8'h0;
      s_reg.adc_start <= 1'b0;
      s_reg.bin_upper <= 4'h0;
      s_reg.bad_upper <= 1'b0;
      s_reg.bin_lower <= 4'h0;
      s_reg.bad_lower <= 1'b0;
      s_reg.address <= 7'h00;
      s_reg.fallback <= 1'b0;
      s_reg.jtag_en <= 1'b0;
      s_reg.clk_div <= 4'h0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign upper_bias_en = pua_bias_on(s_reg.st, 1'b1);
  assign lower_bias_en = pua_bias_on(s_reg.st, 1'b0);
  assign adc_start = s_reg.adc_start;
  assign adc_sel_upper = upper_bias_en;
  assign bus_address = s_reg.address;
  assign address_fallback = s_reg.fallback;
  assign in_run = (s_reg.st == pua_pkg::ST_RUN);
  assign port_off = !s_reg.jtag_en;
  assign address_valid = (s_reg.st == pua_pkg::ST_WAIT_INIT) || in_run;
  assign jtag_enable = s_reg.jtag_en;
  // Programming access only; no scan chain is built into this device
  assign boundary_scan_en = 1'b0;
  assign init_done = in_run;
  // Shared pins are handed to general I/O only in run with the port off
  genvar p;
  generate
    for (p = 0; p < `PUA_SHARED_PINS; p++)
    begin : g_shared
      assign shared_pin_gpio_release[p] = in_run && port_off;
    end
  endgenerate
  // Dropping one enable in ten slows every rate derived from it by the same tenth
  assign sys_clk_en = !(s_reg.jtag_en && s_reg.clk_div == `PUA_CLK_DROP_SLOT);
  assign fast_pulse_width_output_hold_low = !init_done;
  assign pins_float = !init_done;
endmodule // pua_powerup

// [dv/pua_powerup_asserts.sv]
// Port assertions of the power-up block
`include "pua_regs.svh"
module pua_powerup_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ext_reset_n,
  input wire logic upper_bias_en,
  input wire logic lower_bias_en,
  input wire logic adc_start,
  input wire logic adc_sel_upper,
  input wire logic [6:0] bus_address,
  input wire logic address_fallback,
  input wire logic address_valid,
  input wire logic jtag_enable,
  input wire logic boundary_scan_en,
  input wire logic [`PUA_SHARED_PINS-1:0] shared_pin_gpio_release,
  input wire logic sys_clk_en,
  input wire logic fast_pulse_width_output_hold_low,
  input wire logic pins_float,
  input wire logic init_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_start_pulse: assert property (adc_start |-> ((upper_bias_en ^ lower_bias_en) && (adc_sel_upper == upper_bias_en)) ##1 !adc_start)
    else $error("start pulse wrong");
  a_fallback_addr: assert property (address_fallback |-> bus_address == 7'h7E && jtag_enable)
    else $error("fallback address wrong");
  a_gpio_release: assert property (shared_pin_gpio_release == ((init_done && !jtag_enable) ? 4'hF : 4'h0))
    else $error("shared pins wrong");
  a_init_hold: assert property (fast_pulse_width_output_hold_low == !init_done && pins_float == !init_done)
    else $error("init pin state wrong");
  a_decision_held: assert property (address_valid && $past(address_valid) |-> $stable({bus_address, jtag_enable}))
    else $error("decision changed");
  a_clk_rate: assert property (!sys_clk_en |-> jtag_enable ##1 sys_clk_en [*8])
    else $error("clock rate wrong");
  a_no_scan: assert property (!boundary_scan_en)
    else $error("boundary scan on");
  a_exit_quick: assert property ($rose(ext_reset_n) |-> ##[1:12] upper_bias_en)
    else $error("reset exit slow");
endmodule // pua_powerup_asserts
bind pua_powerup pua_powerup_asserts u_checks (
  .mclk(mclk),
  .rstn(rstn),
  .ext_reset_n(ext_reset_n),
  .upper_bias_en(upper_bias_en),
  .lower_bias_en(lower_bias_en),
  .adc_start(adc_start),
  .adc_sel_upper(adc_sel_upper),
  .bus_address(bus_address),
  .address_fallback(address_fallback),
  .address_valid(address_valid),
  .jtag_enable(jtag_enable),
  .boundary_scan_en(boundary_scan_en),
  .shared_pin_gpio_release(shared_pin_gpio_release),
  .sys_clk_en(sys_clk_en),
  .fast_pulse_width_output_hold_low(fast_pulse_width_output_hold_low),
  .pins_float(pins_float),
  .init_done(init_done)
);

// [dv/pua_strap_model.sv]
// Strap resistors and address converter model
module pua_strap_model (
  input wire logic mclk,
  input wire logic upper_bias_en,
  input wire logic lower_bias_en,
  input wire logic adc_start,
  input wire logic adc_sel_upper,
  input wire logic [11:0] upper_code,
  input wire logic [11:0] lower_code,
  input wire logic [3:0] latency,
  output logic adc_done = 1'b0,
  output logic [11:0] adc_code = 12'h5A5
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt = 5'h0;
  always @(posedge mclk)
  begin
    adc_done <= 1'b0;
    // Idle code toggles so a stale value never passes for a result
    adc_code <= ~adc_code;
    if (adc_start)
      cnt <= {1'b1, latency};
    else if (cnt == 5'h10)
    begin
      cnt <= 5'h0;
      adc_done <= 1'b1;
      // An unbiased pin sits near ground
      adc_code <= adc_sel_upper ? (upper_bias_en ? upper_code : 12'h0) : (lower_bias_en ? lower_code : 12'h0);
    end
    else if (cnt[4])
      cnt <= cnt - 5'h1;
  end
endmodule // pua_strap_model

// [dv/test_powerup_address_and_debug_enable.sv]
// Self-checking bench of the power-up block
`include "pua_regs.svh"
module test_powerup_address_and_debug_enable;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 300;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ext_reset_n = 1'b1;
  logic flash_blank = 1'b0;
  logic [11:0] upper_code = 12'h0;
  logic [11:0] lower_code = 12'h0;
  logic [3:0] latency = 4'h0;
  logic upper_bias_en, lower_bias_en, adc_start, adc_sel_upper, adc_done, address_fallback;
  logic address_valid, jtag_enable, init_done, fast_pulse_width_output_hold_low, pins_float;
  logic sys_clk_en, boundary_scan_en;
  logic [11:0] adc_code;
  logic [6:0] bus_address;
  logic [3:0] shared_pin_gpio_release;
  int num_errors = 0;
  int checks_done = 0;
  wire logic [11:0] pin_state = {8'h0, fast_pulse_width_output_hold_low, pins_float, init_done, address_valid};
  wire logic [11:0] dec = {3'h0, bus_address, address_fallback, jtag_enable};
  // First code sits right on the lowest bin edge
  logic [11:0] bin_code [4:11] = '{12'h258, 12'h300, 12'h400, 12'h500, 12'h600, 12'h800, 12'h900, 12'hC00};
  pua_powerup #(.INIT_CYCLES(20'(INIT))) DUT (
    .mclk(mclk),
    .rstn(rstn),
    .ext_reset_n(ext_reset_n),
    .flash_blank(flash_blank),
    .upper_bias_en(upper_bias_en),
    .lower_bias_en(lower_bias_en),
    .adc_start(adc_start),
    .adc_sel_upper(adc_sel_upper),
    .adc_done(adc_done),
    .adc_code(adc_code),
    .bus_address(bus_address),
    .address_fallback(address_fallback),
    .address_valid(address_valid),
    .jtag_enable(jtag_enable),
    .boundary_scan_en(boundary_scan_en),
    .shared_pin_gpio_release(shared_pin_gpio_release),
    .sys_clk_en(sys_clk_en),
    .fast_pulse_width_output_hold_low(fast_pulse_width_output_hold_low),
    .pins_float(pins_float),
    .init_done(init_done)
  );
  pua_strap_model strap (
    .mclk(mclk),
    .upper_bias_en(upper_bias_en),
    .lower_bias_en(lower_bias_en),
    .adc_start(adc_start),
    .adc_sel_upper(adc_sel_upper),
    .upper_code(upper_code),
    .lower_code(lower_code),
    .latency(latency),
    .adc_done(adc_done),
    .adc_code(adc_code)
  );
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Counts dropped clock enables over 40 cycles: four per forty while debugging
  task automatic slow_clock(input logic [11:0] exp);
    logic [11:0] drops;
    drops = 12'h0;
    repeat (40)
    begin
      @(posedge mclk);
      #2;
      drops += {11'h0, !sys_clk_en};
    end
    chk("clock drops", exp, drops);
  endtask
  task automatic boot(input logic [11:0] u, input logic [11:0] l, input logic blank, input logic [3:0] d);
    int n;
    @(posedge mclk);
    #2;
    {upper_code, lower_code, flash_blank, latency} = {u, l, blank, d};
    ext_reset_n = 1'b0;
    repeat (6) @(posedge mclk);
    #2;
    chk("reset pins", 12'hC, pin_state);
    chk("reset decision", 12'h0, dec);
    ext_reset_n = 1'b1;
    for (n = 0; n < 2000 && init_done !== 1'b1; n++)
    begin
      @(posedge mclk);
      #2;
    end
    chk("init span", 12'h1, 12'(n >= INIT && n <= INIT + 12));
    chk("run pins", 12'h3, pin_state);
    chk("scan", 12'h0, {11'h0, boundary_scan_en});
  endtask
  // Pairs keep clear of addresses 0, 11 and 127
  task automatic t_bins();
    for (int i = 0; i < 7; i++)
    begin
      boot(bin_code[4 + i], bin_code[11 - i], 1'b0, 4'(2 * i));
      chk("decision", 12'((12 * (4 + i) + 11 - i) << 2), dec);
      chk("gpio", 12'hF, {8'h0, shared_pin_gpio_release});
      slow_clock(12'h0);
    end
  endtask
  task automatic t_fallback();
    logic [11:0] ups [5] = '{12'h257, 12'h500, 12'hDF8, 12'h500, 12'hC00};
    logic [11:0] los [5] = '{12'h500, 12'h257, 12'h500, 12'hDF8, 12'h258};
    for (int i = 0; i < 5; i++)
    begin
      boot(ups[i], los[i], 1'b0, 4'hF);
      chk("decision", 12'h1FB, dec);
      chk("gpio", 12'h0, {8'h0, shared_pin_gpio_release});
    end
  endtask
  task automatic t_blank_hold();
    boot(bin_code[5], bin_code[6], 1'b1, 4'h3);
    chk("decision", 12'h109, dec);
    chk("gpio", 12'h0, {8'h0, shared_pin_gpio_release});
    {upper_code, flash_blank} = {12'h100, 1'b0};
    slow_clock(12'h4);
    chk("held", 12'h109, dec);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    #2;
    rstn = 1'b1;
    t_bins();
    t_fallback();
    t_blank_hold();
    close_out();
  end
  initial
  begin
    // Thirteen boots of about 330 cycles each fit well inside this span
    #(25 * 20000);
    num_errors++;
    $display("BAD watchdog expected done seen timeout");
    close_out();
  end
endmodule // test_powerup_address_and_debug_enable
